/* sbsts_pkg.sv */
// Package for the secondary bus status register block
package sbsts_pkg;

    localparam logic [7:0]  SBSTS_OFFSET        = 8'h1E;
    localparam int          SBSTS_BIT_PARITY    = 15;
    localparam int          SBSTS_BIT_SERR      = 14;
    localparam int          SBSTS_BIT_RECEIVED_MASTER_ABORT_FLAG    = 13;
    localparam int          SBSTS_BIT_TABORT_RX = 12;
    localparam int          SBSTS_BIT_TABORT_TX = 11;
    localparam int          SBSTS_BIT_MDPAR     = 8;
    localparam int          SBSTS_DEVSEL_MSB    = 10;
    localparam int          SBSTS_DEVSEL_LSB    = 9;
    localparam int          SBSTS_BIT_FBB       = 7;
    localparam int          SBSTS_BIT_RSVD_HI   = 6;
    localparam int          SBSTS_BIT_HS        = 5;
    localparam int          SBSTS_RSVD_LOW_MSB  = 4;
    localparam int          SBSTS_REG_WIDTH     = 16;
    localparam int          SBSTS_FLAG_COUNT    = 6;
    localparam logic [1:0]  SBSTS_DEVSEL_MEDIUM = 2'h1;
    localparam logic        SBSTS_FBB_ONE       = 1'h1;
    localparam logic        SBSTS_HS_ONE        = 1'h1;
    localparam logic [15:0] SBSTS_FLAG_MASK     = 16'hF900;
    localparam logic [15:0] SBSTS_CONST_VALUE   = 16'h02A0;

    // Secondary bus events, one-cycle pulses or levels
    typedef struct packed {
        logic addr_attr_err_target;
        logic write_data_err_target;
        logic read_data_err_master;
        logic serr_seen;
        logic master_abort;
        logic target_abort_rx;
        logic target_abort_tx;
        logic is_master;
        logic perr_driven_read;
        logic perr_seen_write;
    } sbsts_evt_t;

    // Configuration access port
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } sbsts_cfg_t;

endpackage : sbsts_pkg

/* sbsts_flag.sv */
// One sticky write-one-to-clear status flag
`timescale 1ns/1ps
`default_nettype none
module sbsts_flag
    import sbsts_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic set_i,
    input  wire logic clr_i,
    output var  logic flag_q
);
    logic flag_d;

    // Set beats clear in the same cycle
    always_comb
    begin
        flag_d = (flag_q & ~clr_i) | set_i;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            flag_q <= 1'h0;
        else
            flag_q <= flag_d;
    end
endmodule : sbsts_flag
`default_nettype wire

/* sbsts_reg.sv */
// Secondary bus status register: sticky event flags and fixed capabilities
// What this block does
// - Set parity flag on target address, target write data or master read data errors
// - Parity flag set regardless of the parity response enable
// - Set system error flag in bit 14 when SERR seen on secondary bus
// - Set master abort flag in bit 13 on master abort of own transaction
// - Set target abort received flag in bit 12 on received target abort
// - Set target abort signaled flag in bit 11 when signaling target abort
// - Bits 10:9 read 01b, medium DEVSEL timing
// - Bit 8 set when master, parity response enabled, and PERR driven/seen
// - Bit 7 reads constant 1, fast back-to-back capable
// - Bit 5 always reads 1, 66 MHz capable
// - Reserved bits 6 and 4:0 read zero, writes ignored
// - Register at offset 1Eh; capabilities read-only, flags hold until cleared
`timescale 1ns/1ps
`default_nettype none
module sbsts_reg
    import sbsts_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire sbsts_cfg_t cfg,
    input  wire sbsts_evt_t evt,
    input  wire logic       parity_response_enable,
    output var  logic [15:0] rdata_q,
    output var  logic       rvalid_q
);
    ////////////////////////////////////////////////////////////////////////////
    // Event decode
    logic                  hit;
    logic [15:0]           set_vec;
    logic [15:0]           clr_vec;
    logic [15:0]           flags;
    logic [15:0]           status;
    logic [15:0]           rdata_d;
    logic                  rvalid_d;

    always_comb
    begin
        hit     = (cfg.addr == SBSTS_OFFSET);
        set_vec = 16'h0000;
        // No enable term here by design
        set_vec[SBSTS_BIT_PARITY] = evt.addr_attr_err_target | evt.write_data_err_target
                                  | evt.read_data_err_master;
        set_vec[SBSTS_BIT_SERR]      = evt.serr_seen;
        set_vec[SBSTS_BIT_RECEIVED_MASTER_ABORT_FLAG]    = evt.master_abort;
        set_vec[SBSTS_BIT_TABORT_RX] = evt.target_abort_rx;
        set_vec[SBSTS_BIT_TABORT_TX] = evt.target_abort_tx;
        set_vec[SBSTS_BIT_MDPAR]     = evt.is_master & parity_response_enable
                                     & (evt.perr_driven_read | evt.perr_seen_write);
        // Write-one-to-clear, only on flag positions
        clr_vec = (cfg.wr && hit) ? (cfg.wdata & SBSTS_FLAG_MASK) : 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags, one per event bit
    genvar gi;
    generate
        for (gi = 0; gi < SBSTS_REG_WIDTH; gi++)
        begin : g_flag
            if (SBSTS_FLAG_MASK[gi])
            begin : g_live
                sbsts_flag u_flag (
                    .sys_clk (sys_clk),
                    .rst_b   (rst_b),
                    .set_i   (set_vec[gi]),
                    .clr_i   (clr_vec[gi]),
                    .flag_q  (flags[gi])
                );
            end
            else
            begin : g_const
                assign flags[gi] = 1'h0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    always_comb
    begin
        status      = flags;
        // Fixed bits overwrite the zero flag slots, so no write can reach them
        status[SBSTS_DEVSEL_MSB:SBSTS_DEVSEL_LSB] = SBSTS_DEVSEL_MEDIUM;
        status[SBSTS_BIT_FBB]                     = SBSTS_FBB_ONE;
        status[SBSTS_BIT_HS]                      = SBSTS_HS_ONE;
        status[SBSTS_BIT_RSVD_HI]                 = 1'h0;
        status[SBSTS_RSVD_LOW_MSB:0]              = 5'h00;
        rvalid_d    = cfg.rd;
        rdata_d     = (cfg.rd && hit) ? status : 16'h0000;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'h0;
        end
        else
        begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_PARITY_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (evt.addr_attr_err_target | evt.write_data_err_target | evt.read_data_err_master)
        |=> flags[SBSTS_BIT_PARITY])
        else $error("parity flag not set");
    AST_PARITY_NO_EN: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!parity_response_enable && evt.write_data_err_target) |=> flags[SBSTS_BIT_PARITY])
        else $error("parity flag gated by enable");
    AST_SERR_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
        evt.serr_seen |=> flags[SBSTS_BIT_SERR])
        else $error("system error flag not set");
    AST_RECEIVED_MASTER_ABORT_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
        evt.master_abort |=> flags[SBSTS_BIT_RECEIVED_MASTER_ABORT_FLAG])
        else $error("master abort flag not set");
    AST_TABORT_RX_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
        evt.target_abort_rx |=> flags[SBSTS_BIT_TABORT_RX])
        else $error("target abort received flag not set");
    AST_TABORT_TX_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
        evt.target_abort_tx |=> flags[SBSTS_BIT_TABORT_TX])
        else $error("target abort signaled flag not set");
    AST_MDPAR_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(flags[SBSTS_BIT_MDPAR]) |-> $past(parity_response_enable && evt.is_master))
        else $error("master data parity flag set without cause");
    AST_CONST_READ: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (cfg.rd && hit) |=> (rdata_q[10:9] == 2'h1 && rdata_q[7] && rdata_q[5]
                             && rdata_q[6] == 1'h0 && rdata_q[4:0] == 5'h00))
        else $error("capability or reserved bits wrong");
    AST_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (flags[SBSTS_BIT_SERR] && !(cfg.wr && hit && cfg.wdata[SBSTS_BIT_SERR]))
        |=> flags[SBSTS_BIT_SERR])
        else $error("flag dropped without clear");
    AST_W1C: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (cfg.wr && hit && cfg.wdata[SBSTS_BIT_RECEIVED_MASTER_ABORT_FLAG] && !evt.master_abort)
        |=> !flags[SBSTS_BIT_RECEIVED_MASTER_ABORT_FLAG])
        else $error("write one did not clear flag");

    ////////////////////////////////////////////////////////////////////////////
    // Further checks on event capture, the read path and the clear rule
    AST_PARITY_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        evt.addr_attr_err_target |=> flags[SBSTS_BIT_PARITY])
        else $error("address error did not set parity flag");
    AST_PARITY_RDATA: assert property (@(posedge sys_clk) disable iff (!rst_b)
        evt.read_data_err_master |=> flags[SBSTS_BIT_PARITY])
        else $error("read data error did not set parity flag");
    AST_MDPAR_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (evt.is_master && parity_response_enable
         && (evt.perr_driven_read || evt.perr_seen_write))
        |=> flags[SBSTS_BIT_MDPAR])
        else $error("master data parity flag not set");
    AST_MDPAR_NO_EN: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!flags[SBSTS_BIT_MDPAR] && !parity_response_enable)
        |=> !flags[SBSTS_BIT_MDPAR])
        else $error("master data parity flag set with response disabled");
    AST_MDPAR_NOT_MASTER: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!flags[SBSTS_BIT_MDPAR] && !evt.is_master)
        |=> !flags[SBSTS_BIT_MDPAR])
        else $error("master data parity flag set while not master");
    AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (evt.serr_seen && cfg.wr && hit) |=> flags[SBSTS_BIT_SERR])
        else $error("clear beat a same cycle event");
    AST_W0_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (flags[SBSTS_BIT_TABORT_RX] && cfg.wr && hit && !cfg.wdata[SBSTS_BIT_TABORT_RX])
        |=> flags[SBSTS_BIT_TABORT_RX])
        else $error("write zero changed a flag");
    AST_OTHER_WR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (flags[SBSTS_BIT_PARITY] && cfg.wr && !hit) |=> flags[SBSTS_BIT_PARITY])
        else $error("write to another offset cleared a flag");
    AST_NO_SPARE_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (flags & ~SBSTS_FLAG_MASK) == 16'h0000)
        else $error("flag outside the event positions");
    AST_RVALID: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cfg.rd |=> rvalid_q)
        else $error("read not answered in one cycle");
    AST_NO_RVALID: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !cfg.rd |=> !rvalid_q)
        else $error("answer without a read");
    AST_UNMAPPED: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (cfg.rd && !hit) |=> (rdata_q == 16'h0000))
        else $error("other offset did not read zero");
    AST_READ_FLAGS: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (cfg.rd && hit) |=> ((rdata_q & SBSTS_FLAG_MASK) == $past(flags)))
        else $error("read data does not show flags");
endmodule : sbsts_reg
`default_nettype wire

/* sbsts_bus_model.sv */
// Secondary bus agent model raising event lines toward the status block
`timescale 1ns/1ps
`default_nettype none
module sbsts_bus_model
    import sbsts_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire sbsts_evt_t req,
    output var  sbsts_evt_t evt
);
    // Events follow req one cycle late; lines fall back to idle low when req does, or at once on reset
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
            evt <= '0;
        else
            evt <= req;
endmodule : sbsts_bus_model
`default_nettype wire

/* secondary_bus_status_tb_top.sv */
// Self-checking testbench for the secondary bus status register
`timescale 1ns/1ps
`default_nettype none
module secondary_bus_status_tb_top;
    import sbsts_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_b   = 1'b0;
    logic        pre     = 1'b0;
    sbsts_cfg_t  cfg     = '0;
    sbsts_evt_t  req     = '0;
    sbsts_evt_t  evt;
    logic [15:0] rdata_q;
    logic        rvalid_q;
    logic [15:0] lfsr    = 16'hA283;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    logic [15:0] fl;
    int          error_cnt   = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    sbsts_reg i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .cfg(cfg), .evt(evt),
        .parity_response_enable(pre), .rdata_q(rdata_q), .rvalid_q(rvalid_q));
    sbsts_bus_model i_bus (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .evt(evt));
    initial forever #20 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt
    function automatic logic [15:0] flg(input int i, input logic p);
        if (i >= 7)
            return 16'h8000;
        if (i >= 3)
            return 16'h0001 << (i + 8);
        return (i < 2 && p) ? 16'h0100 : 16'h0000;
    endfunction : flg
    task automatic acc(input logic r, input logic [7:0] a, input logic [15:0] d);
        cfg <= '{rd: r, wr: !r, addr: a, wdata: d};
        @(posedge sys_clk);
        cfg <= '0;
        @(posedge sys_clk);
    endtask : acc
    task automatic rd(input logic [7:0] a, input logic [15:0] x);
        exp_q.push_back(x);
        acc(1'b1, a, 16'h0000);
    endtask : rd
    task automatic stop_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////
    // Settled half a cycle after the edge that raised the answer
    always @(negedge sys_clk)
        if (rvalid_q === 1'b1)
        begin
            e = exp_q.pop_front();
            comparisons++;
            if (rdata_q !== e)
            begin
                error_cnt++;
                $display("[ERR] %0t got %h exp %h", $time, rdata_q, e);
            end
        end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rd(SBSTS_OFFSET, SBSTS_CONST_VALUE);
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 10; i++)
            begin
                lfsr = nxt(lfsr);
                pre <= p[0];
                fl = flg(i, p[0]);
                req <= sbsts_evt_t'((10'h001 << i) | ((i < 2) ? 10'h004 : 10'h000));
                @(posedge sys_clk);
                req <= '0;
                repeat (2) @(posedge sys_clk);
                rd(SBSTS_OFFSET, SBSTS_CONST_VALUE | fl);
                acc(1'b0, 8'h1F, lfsr);
                rd(8'h1F, 16'h0000);
                acc(1'b0, SBSTS_OFFSET, lfsr & ~SBSTS_FLAG_MASK);
                rd(SBSTS_OFFSET, SBSTS_CONST_VALUE | fl);
                acc(1'b0, SBSTS_OFFSET, 16'hFFFF);
                rd(SBSTS_OFFSET, SBSTS_CONST_VALUE);
            end
        // Event and clear in the same cycle: the event must win
        req <= '{serr_seen: 1'b1, default: 1'b0};
        @(posedge sys_clk);
        req <= '0;
        acc(1'b0, SBSTS_OFFSET, 16'hFFFF);
        rd(SBSTS_OFFSET, SBSTS_CONST_VALUE | 16'h4000);
        acc(1'b0, SBSTS_OFFSET, 16'hFFFF);
        rd(SBSTS_OFFSET, SBSTS_CONST_VALUE);
        repeat (3) @(posedge sys_clk);
        stop_test();
    end
endmodule : secondary_bus_status_tb_top
`default_nettype wire
